// file: rtl/scil_pkg.sv
// shared constants and types for the safety curtain indicator logic
package scil_pkg;

  // =========================================================
  // timing
  localparam int CLK_HZ = 200_000_000;
  localparam int FLASH_HALF_MS = 250;
  localparam int FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;
  localparam int TB_W = 26;
  localparam int SCAN_FLASHES = 3;
  localparam int SCAN_PHASES = 2 * SCAN_FLASHES;
  localparam int ZONES = 8;

  // =========================================================
  // register map
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_IRQ_STAT = 4'h1;
  localparam logic [3:0] REG_IRQ_MASK = 4'h2;
  localparam logic [3:0] REG_STATE = 4'h3;
  localparam int CTRL_W = 8;
  localparam int CTRL_LAMP_EN = 0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h01;
  localparam int IRQ_W = 4;
  localparam int IRQ_RX_LOCK = 0;
  localparam int IRQ_EM_LOCK = 1;
  localparam int IRQ_SCAN_CHG = 2;
  localparam int IRQ_SYNC_LOSS = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // =========================================================
  // types
  typedef enum logic [2:0] {
    MODE_ALIGN = 3'h0,
    MODE_RUN = 3'h1,
    MODE_WAIT_RESET = 3'h2,
    MODE_LOCKOUT = 3'h3
  } scil_mode_t;

  typedef enum logic [2:0] {
    ST_POWERUP = 3'h1,
    ST_SCAN = 3'h2,
    ST_NORMAL = 3'h4
  } scil_state_t;

  typedef enum logic [2:0] {
    DK_BLANK = 3'h0,
    DK_DASH = 3'h1,
    DK_LATCH = 3'h2,
    DK_SCAN = 3'h3,
    DK_ERROR = 3'h4,
    DK_COUNT = 3'h5
  } scil_disp_kind_t;

  typedef struct packed {
    logic red;
    logic green;
  } scil_lamp_t;

  typedef struct packed {
    scil_disp_kind_t kind;
    logic [7:0] value;
  } scil_disp_t;

  typedef struct packed {
    scil_mode_t mode;
    logic latch_cfg;
    logic scan_code;
    logic coarse_detection_option;
    logic safety_switching_outputs;
    logic beam1_blocked;
    logic [ZONES-1:0] zone_blocked;
    logic [ZONES-1:0] zone_blanked;
    logic [7:0] blocked_count;
    logic [7:0] rx_error;
    logic em_fault;
    logic [7:0] em_error;
    logic em_test;
  } scil_core_t;

  typedef struct packed {
    logic rx_reset_lamp;
    scil_lamp_t rx_status;
    logic [ZONES-1:0] zone_red;
    logic [ZONES-1:0] zone_green;
    scil_disp_t rx_disp;
    scil_lamp_t em_status;
    scil_disp_t em_disp;
  } scil_ind_t;

endpackage

// file: rtl/scil_indicator.sv
// indicator driver for the emitter and receiver lamps and displays
`timescale 1ns/1ps
`default_nettype none

module scil_indicator
  import scil_pkg::*;
#(
  parameter int unsigned FLASH_HALF_CYC_P = FLASH_HALF_CYC
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire scil_core_t core,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic irq,
  output scil_ind_t ind
);

  // =========================================================
  // state
  typedef struct packed {
    scil_state_t st;
    logic [TB_W-1:0] tb_cnt;
    logic phase;
    logic [2:0] phase_cnt;
    logic em_lock;
    logic scan_d;
    logic rx_lock_d;
    logic beam1_d;
    logic [CTRL_W-1:0] ctrl;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic [31:0] rdata;
    scil_ind_t ind;
  } scil_regs_t;

  scil_regs_t q;
  scil_regs_t n;

  localparam logic [TB_W-1:0] TB_LAST = TB_W'(FLASH_HALF_CYC_P - 1);
  localparam logic [TB_W-1:0] TB_Q1 = TB_W'(FLASH_HALF_CYC_P / 4);
  localparam logic [TB_W-1:0] TB_Q2 = TB_W'(FLASH_HALF_CYC_P / 2);
  localparam logic [TB_W-1:0] TB_Q3 = TB_W'(FLASH_HALF_CYC_P * 3 / 4);
  localparam logic [2:0] PH_LAST = 3'(SCAN_PHASES - 1);

  logic tick;
  logic flash_on;
  logic dbl_on;
  logic showing;
  logic rx_lock;
  logic scan_chg;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] rd_clr;
  logic wr_ctrl;
  logic wr_mask;
  logic rd_stat;

  // =========================================================
  // shared timebase
  // every flashing pattern below is gated by flash_on, so the lamps
  // and displays stay in phase with each other
  assign tick = (q.tb_cnt == TB_LAST);
  assign flash_on = ~q.phase;
  // double flash: two short pulses inside the on half
  assign dbl_on = flash_on &&
    ((q.tb_cnt < TB_Q1) || ((q.tb_cnt >= TB_Q2) && (q.tb_cnt < TB_Q3)));
  assign showing = (q.st != ST_NORMAL);
  assign rx_lock = (core.mode == MODE_LOCKOUT);
  assign scan_chg = (core.scan_code != q.scan_d);

  // =========================================================
  // events and register strobes
  always_comb
  begin
    ev = '0;
    ev[IRQ_RX_LOCK] = rx_lock && !q.rx_lock_d;
    ev[IRQ_EM_LOCK] = core.em_fault && !q.em_lock;
    ev[IRQ_SCAN_CHG] = scan_chg && (q.st == ST_NORMAL);
    ev[IRQ_SYNC_LOSS] = core.beam1_blocked && !q.beam1_d;
  end

  assign wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
  assign wr_mask = reg_wr && (reg_addr == REG_IRQ_MASK);
  assign rd_stat = reg_rd && (reg_addr == REG_IRQ_STAT);
  assign rd_clr = rd_stat ? q.irq_stat : '0;

  // =========================================================
  // next state
  always_comb
  begin
    n = q;

    // free-running timebase
    if (tick)
    begin
      n.tb_cnt = '0;
      n.phase = ~q.phase;
    end
    else
    begin
      n.tb_cnt = q.tb_cnt + 1'b1;
    end

    // scan code presentation sequencer
    case (q.st)
      ST_POWERUP,
      ST_SCAN:
      begin
        if (tick)
        begin
          if (q.phase_cnt == PH_LAST)
          begin
            n.st = ST_NORMAL;
            n.phase_cnt = '0;
          end
          else
          begin
            n.phase_cnt = q.phase_cnt + 1'b1;
          end
        end
      end
      ST_NORMAL:
      begin
        if (scan_chg)
        begin
          n.st = ST_SCAN;
          n.phase_cnt = '0;
        end
      end
      default:
      begin
        n.st = ST_NORMAL;
        n.phase_cnt = '0;
      end
    endcase

    n.scan_d = core.scan_code;
    n.rx_lock_d = rx_lock;
    n.beam1_d = core.beam1_blocked;

    // the emitter lockout is sticky: only sys_rst, i.e. a power
    // cycle, clears it; there is no software or reset-input path
    if (core.em_fault)
    begin
      n.em_lock = 1'b1;
    end

    // registers; a new event wins over the read that clears it
    if (wr_ctrl)
    begin
      n.ctrl = reg_wdata[CTRL_W-1:0];
    end
    if (wr_mask)
    begin
      n.irq_mask = reg_wdata[IRQ_W-1:0];
    end
    n.irq_stat = (q.irq_stat & ~rd_clr) | ev;

    // read data stands for the one cycle after the strobe only
    n.rdata = '0;
    if (reg_rd)
    begin
      if (reg_addr == REG_CTRL)
      begin
        n.rdata = 32'(q.ctrl);
      end
      else if (reg_addr == REG_IRQ_STAT)
      begin
        n.rdata = 32'(q.irq_stat);
      end
      else if (reg_addr == REG_IRQ_MASK)
      begin
        n.rdata = 32'(q.irq_mask);
      end
      else if (reg_addr == REG_STATE)
      begin
        n.rdata = 32'({q.ind.rx_disp.kind, core.mode, q.phase,
                       q.em_lock, q.st});
      end
      else
      begin
        n.rdata = '0;
      end
    end

    // -------------------------------------------------------
    // receiver reset lamp
    n.ind.rx_reset_lamp = 1'b0;
    if (q.st == ST_POWERUP || rx_lock)
    begin
      n.ind.rx_reset_lamp = 1'b0;
    end
    else if (core.mode == MODE_RUN)
    begin
      n.ind.rx_reset_lamp = 1'b1;
    end
    else if (core.mode == MODE_WAIT_RESET)
    begin
      n.ind.rx_reset_lamp = flash_on;
    end
    else if (core.mode == MODE_ALIGN && !core.beam1_blocked)
    begin
      if (core.blocked_count == '0)
      begin
        n.ind.rx_reset_lamp = dbl_on;
      end
      else
      begin
        n.ind.rx_reset_lamp = 1'b1;
      end
    end

    // -------------------------------------------------------
    // receiver status lamp
    n.ind.rx_status = '0;
    if (rx_lock)
    begin
      n.ind.rx_status.red = flash_on;
    end
    else if (q.st == ST_POWERUP)
    begin
      // single flash: red in the first half period only
      n.ind.rx_status.red = (q.phase_cnt == '0) && flash_on;
    end
    else if (core.mode == MODE_ALIGN && core.beam1_blocked)
    begin
      n.ind.rx_status = '0;
    end
    else if (core.safety_switching_outputs)
    begin
      if (core.coarse_detection_option)
      begin
        n.ind.rx_status.green = flash_on;
      end
      else
      begin
        n.ind.rx_status.green = 1'b1;
      end
    end
    else
    begin
      n.ind.rx_status.red = 1'b1;
    end

    // -------------------------------------------------------
    // zone lamps, each summarising one eighth of the beams
    for (int i = 0; i < ZONES; i++)
    begin
      n.ind.zone_red[i] = 1'b0;
      n.ind.zone_green[i] = 1'b0;
      if (rx_lock)
      begin
        n.ind.zone_red[i] = 1'b0;
      end
      else if (q.st == ST_POWERUP)
      begin
        n.ind.zone_red[i] = (q.phase_cnt == '0) && flash_on;
      end
      else if (core.beam1_blocked)
      begin
        // without sync from the first beam the rest is unknown
        n.ind.zone_red[i] = (i == 0);
      end
      else if (core.zone_blocked[i])
      begin
        n.ind.zone_red[i] = 1'b1;
      end
      else if (core.zone_blanked[i])
      begin
        n.ind.zone_green[i] = flash_on;
      end
      else
      begin
        n.ind.zone_green[i] = 1'b1;
      end
    end

    // -------------------------------------------------------
    // receiver three-digit display
    n.ind.rx_disp.kind = DK_BLANK;
    n.ind.rx_disp.value = '0;
    if (rx_lock)
    begin
      n.ind.rx_disp.kind = DK_ERROR;
      n.ind.rx_disp.value = core.rx_error;
    end
    else if (showing)
    begin
      // scan code blinks once per period, three times in all
      if (flash_on)
      begin
        n.ind.rx_disp.kind = DK_SCAN;
        n.ind.rx_disp.value = 8'(core.scan_code);
      end
    end
    else if (core.mode == MODE_ALIGN ||
             core.blocked_count != '0)
    begin
      n.ind.rx_disp.kind = DK_COUNT;
      n.ind.rx_disp.value = core.blocked_count;
    end
    else if (core.latch_cfg)
    begin
      n.ind.rx_disp.kind = DK_LATCH;
    end
    else
    begin
      n.ind.rx_disp.kind = DK_DASH;
    end

    // -------------------------------------------------------
    // emitter status lamp
    n.ind.em_status = '0;
    if (q.st == ST_POWERUP)
    begin
      n.ind.em_status.red = (q.phase_cnt == '0) && flash_on;
    end
    else if (q.em_lock)
    begin
      n.ind.em_status.red = flash_on;
    end
    else if (core.em_test)
    begin
      n.ind.em_status.green = flash_on;
    end
    else
    begin
      n.ind.em_status.green = 1'b1;
    end

    // -------------------------------------------------------
    // emitter one-digit display
    n.ind.em_disp.kind = DK_BLANK;
    n.ind.em_disp.value = '0;
    if (q.em_lock)
    begin
      n.ind.em_disp.kind = DK_ERROR;
      n.ind.em_disp.value = core.em_error;
    end
    else if (showing && flash_on)
    begin
      n.ind.em_disp.kind = DK_SCAN;
      n.ind.em_disp.value = 8'(core.scan_code);
    end

    // software lamp blanking; displays keep running so that an
    // error code is never hidden
    if (!q.ctrl[CTRL_LAMP_EN])
    begin
      n.ind.rx_reset_lamp = 1'b0;
      n.ind.rx_status = '0;
      n.ind.zone_red = '0;
      n.ind.zone_green = '0;
      n.ind.em_status = '0;
    end
  end

  // =========================================================
  // registers
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      q <= '0;
      q.st <= ST_POWERUP;
      q.ctrl <= CTRL_RST;
      q.irq_mask <= IRQ_MASK_RST;
    end
    else
    begin
      q <= n;
    end
  end

  // =========================================================
  // outputs
  assign reg_rdata = q.rdata;
  assign irq = |(q.irq_stat & q.irq_mask);
  assign ind = q.ind;

endmodule

`default_nettype wire

// file: verif/scil_chk.sv
// port checker for the indicator driver, bound into its top module
`timescale 1ns/1ps
`default_nettype none

module scil_chk
  import scil_pkg::*;
#(
  parameter int unsigned FLASH_HALF_CYC_P = FLASH_HALF_CYC
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire scil_core_t core,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic irq,
  input wire scil_ind_t ind
);
  // ==========
  // helper state
  // quiet hides the scan code windows after reset and after a code change
  logic [31:0] q_cnt;
  logic [15:0] g_run;
  logic en_reg;
  logic en_q;
  logic sc_q;
  // the status lamp follows the option one cycle late
  logic cd_q;
  wire logic quiet = q_cnt > 8 * FLASH_HALF_CYC_P;
  // lamp enable held over two cycles, whichever cycle the design uses
  wire logic en2 = en_reg && en_q;

  always_ff @(posedge ref_clk)
  begin
    sc_q <= core.scan_code;
    cd_q <= core.coarse_detection_option;
    en_q <= sys_rst || en_reg;
    if (sys_rst || sc_q != core.scan_code)
      q_cnt <= '0;
    else if (!quiet)
      q_cnt <= q_cnt + 1;
    if (sys_rst)
      en_reg <= 1'b1;
    else if (reg_wr && reg_addr == REG_CTRL)
      en_reg <= reg_wdata[CTRL_LAMP_EN];
    if (sys_rst || !cd_q || !core.coarse_detection_option ||
        !ind.rx_status.green)
      g_run <= '0;
    else
      g_run <= g_run + 16'h1;
  end

  // ==========
  // assertions
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  AST_LOCK_ZONES: assert property (
    core.mode == MODE_LOCKOUT |=> ind.zone_red == '0 && ind.zone_green == '0)
    else $error("zone lamps lit in lockout");
  AST_LOCK_GREEN: assert property (
    core.mode == MODE_LOCKOUT |=> !ind.rx_status.green && !ind.rx_reset_lamp)
    else $error("green or reset lamp in lockout");
  AST_LOCK_ERR: assert property (
    core.mode == MODE_LOCKOUT |=> ind.rx_disp.kind == DK_ERROR
      && ind.rx_disp.value == $past(core.rx_error))
    else $error("lockout display wrong");
  AST_B1_ZONES: assert property (
    quiet && core.beam1_blocked |=> ind.zone_red[7:1] == '0
      && ind.zone_green[7:1] == '0)
    else $error("zones two to eight lit with beam one blocked");
  AST_B1_ZONE1: assert property (
    quiet && en2 && core.beam1_blocked && core.mode != MODE_LOCKOUT
      |=> ind.zone_red[0] && !ind.zone_green[0])
    else $error("zone one not red with beam one blocked");
  AST_ZONE_RED: assert property (
    quiet && en2 && !core.beam1_blocked && core.mode != MODE_LOCKOUT
      |=> ind.zone_red == $past(core.zone_blocked))
    else $error("zone red lamps differ from blocked zones");
  AST_GREEN_OUT: assert property (
    ind.rx_status.green |-> $past(core.safety_switching_outputs))
    else $error("status green with outputs off");
  AST_COARSE: assert property (g_run <= FLASH_HALF_CYC_P)
    else $error("green not flashing with coarse option");
  AST_RUN_LAMP: assert property (
    quiet && en2 && core.mode == MODE_RUN |=> ind.rx_reset_lamp)
    else $error("reset lamp off in run");
  AST_EM_STICKY: assert property (
    ind.em_disp.kind == DK_ERROR |=> ind.em_disp.kind == DK_ERROR)
    else $error("emitter lockout left without power cycle");

  cover property (core.mode == MODE_LOCKOUT ##1 irq);
  cover property (g_run == 16'h8);
  cover property (ind.em_disp.kind == DK_ERROR);
endmodule

bind scil_indicator scil_chk #(.FLASH_HALF_CYC_P(FLASH_HALF_CYC_P)) u_chk (
  .ref_clk(ref_clk),
  .sys_rst(sys_rst),
  .core(core),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .irq(irq),
  .ind(ind)
);
`default_nettype wire

// file: verif/scil_panel_model.sv
// operator panel model: counts what an onlooker sees on the receiver status and reset lamps and the receiver display
`timescale 1ns/1ps
`default_nettype none

module scil_panel_model
  import scil_pkg::*;
(
  input wire logic ref_clk,
  input wire logic clr,
  input wire scil_ind_t ind,
  output logic [7:0] scan_blinks,
  output logic [7:0] red_rises,
  output logic [7:0] rst_tog,
  output logic [7:0] grn_tog
);
  scil_ind_t prev;

  always @(posedge ref_clk)
  begin
    prev <= ind;
    if (clr)
    begin
      scan_blinks <= '0;
      red_rises <= '0;
      rst_tog <= '0;
      grn_tog <= '0;
    end
    else
    begin
      // a blink is the display entering the scan code from anything else
      if (ind.rx_disp.kind == DK_SCAN && prev.rx_disp.kind != DK_SCAN)
        scan_blinks <= scan_blinks + 8'h1;
      if (ind.rx_status.red && !prev.rx_status.red)
        red_rises <= red_rises + 8'h1;
      if (ind.rx_reset_lamp != prev.rx_reset_lamp)
        rst_tog <= rst_tog + 8'h1;
      if (ind.rx_status.green != prev.rx_status.green)
        grn_tog <= grn_tog + 8'h1;
    end
  end
endmodule
`default_nettype wire

// file: verif/scil_indicator_tb.sv
// self-checking bench for the indicator driver
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
  num_errors++; $display("[ERR] %s exp %0h got %0h", n, e, a); end end

module scil_indicator_tb
  import scil_pkg::*;
;
  // short flash period keeps the scan windows to about a hundred cycles
  localparam int H = 16;
  localparam int PU = 6 * H + 8;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  scil_core_t core = '0;
  logic [3:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic irq;
  scil_ind_t ind;
  scil_ind_t e;
  scil_core_t c;
  logic [7:0] sb, rr, rt, gt, g0;
  logic [31:0] d;
  int num_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 9443;

  always #2.5 ref_clk = ~ref_clk;

  scil_indicator #(.FLASH_HALF_CYC_P(H)) u_dut (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .core(core), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .ind(ind));
  scil_panel_model u_panel (.ref_clk(ref_clk), .clr(sys_rst), .ind(ind),
    .scan_blinks(sb), .red_rises(rr), .rst_tog(rt), .grn_tog(gt));

  // ==========
  // tasks
  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task put(input int n);
    @(posedge ref_clk);
    core <= c;
    tick(n);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task final_report;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // receiver lamps and display for an unlocked core with outputs off
  function automatic scil_ind_t exp_rx(input scil_core_t v);
    exp_rx = '0;
    exp_rx.rx_disp = {DK_COUNT, v.blocked_count};
    exp_rx.rx_reset_lamp = v.mode == MODE_RUN || !v.beam1_blocked;
    exp_rx.rx_status.red = v.mode != MODE_ALIGN || !v.beam1_blocked;
    exp_rx.zone_red = v.beam1_blocked ? 8'h01 : v.zone_blocked;
    exp_rx.zone_green = v.beam1_blocked ? 8'h00 : ~v.zone_blocked;
  endfunction

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      final_report;
    end
  end

  // ==========
  // sequence
  initial
  begin
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    c = '0;
    c.mode = MODE_RUN;
    c.safety_switching_outputs = 1'b1;
    put(PU);
    `CHK("scan blinks", 8'd3, sb)
    `CHK("red single flash", 8'd1, rr)
    `CHK("trip dash", DK_DASH, ind.rx_disp.kind)
    g0 = gt;
    tick(3 * H);
    `CHK("steady green", 2'b01, ind.rx_status)
    `CHK("no green toggle", 8'h0, gt - g0)
    c.latch_cfg = 1'b1;
    c.coarse_detection_option = 1'b1;
    put(3 * H);
    `CHK("latch letter", DK_LATCH, ind.rx_disp.kind)
    `CHK("green flash", 1'b1, gt != g0)
    $display("test run done");
    c.mode = MODE_WAIT_RESET;
    c.safety_switching_outputs = 1'b0;
    g0 = rt;
    put(3 * H);
    `CHK("reset flash", 1'b1, rt - g0 >= 8'd2)
    `CHK("status red", 2'b10, ind.rx_status)
    rd(REG_CTRL);
    `CHK("ctrl reset", 32'h1, d)
    wr(REG_STATE, '1);
    rd(REG_STATE);
    `CHK("state normal", 3'h4, d[2:0])
    rd(4'h9);
    `CHK("unmapped", 32'h0, d)
    rd(REG_IRQ_MASK);
    `CHK("mask reset", 32'h0, d)
    wr(REG_IRQ_MASK, 32'h1);
    $display("test registers done");
    for (int i = 0; i < 16; i++)
    begin
      c.mode = i[0] ? MODE_ALIGN : MODE_RUN;
      c.beam1_blocked = i[1];
      c.zone_blocked = 8'($random(seed)) | {7'h0, i[1]};
      c.blocked_count = 8'($random(seed)) | 8'h01;
      put(2);
      e = exp_rx(c);
      `CHK("reset lamp", e.rx_reset_lamp, ind.rx_reset_lamp)
      `CHK("status lamp", e.rx_status, ind.rx_status)
      `CHK("zone red", e.zone_red, ind.zone_red)
      `CHK("zone green", e.zone_green, ind.zone_green)
      `CHK("rx display", e.rx_disp, ind.rx_disp)
    end
    // blanked zone eight and emitter test mode green toggle every half period
    c.mode = MODE_RUN;
    c.beam1_blocked = 1'b0;
    c.zone_blocked = 8'h00;
    c.zone_blanked = 8'h80;
    c.em_test = 1'b1;
    put(2);
    g0 = {6'h0, ind.zone_green[7], ind.em_status.green};
    tick(H);
    `CHK("blank flash", ~g0[1], ind.zone_green[7])
    `CHK("blank red", 1'b0, ind.zone_red[7])
    `CHK("em test flash", ~g0[0], ind.em_status.green)
    wr(REG_CTRL, 32'h0);
    tick(2);
    `CHK("lamps off", 19'h0, {ind.rx_status, ind.zone_red, ind.zone_green,
      ind.rx_reset_lamp})
    `CHK("display kept", DK_COUNT, ind.rx_disp.kind)
    wr(REG_CTRL, 32'h1);
    rd(REG_IRQ_STAT);
    $display("test zones done");
    c.mode = MODE_LOCKOUT;
    c.rx_error = 8'($random(seed));
    g0 = rr;
    // two full flash periods always hold two rising edges of red
    put(4 * H);
    `CHK("lock irq", 1'b1, irq)
    `CHK("lock zones", 16'h0, {ind.zone_red, ind.zone_green})
    `CHK("lock flash", 1'b1, rr - g0 >= 8'd2)
    `CHK("lock code", {DK_ERROR, c.rx_error}, ind.rx_disp)
    rd(REG_IRQ_STAT);
    `CHK("stat lock", 4'h1, d[3:0])
    `CHK("irq cleared", 1'b0, irq)
    wr(REG_IRQ_MASK, 32'h0);
    // the core lets go of lockout only after a reset closure of legal length
    c.mode = MODE_RUN;
    c.beam1_blocked = 1'b0;
    put(2);
    c.beam1_blocked = 1'b1;
    put(2);
    `CHK("masked irq", 1'b0, irq)
    rd(REG_IRQ_STAT);
    `CHK("stat sync", 4'h8, d[3:0])
    $display("test lockout done");
    c.beam1_blocked = 1'b0;
    c.scan_code = 1'b1;
    g0 = sb;
    put(PU);
    `CHK("scan change", 8'd3, sb - g0)
    rd(REG_IRQ_STAT);
    `CHK("stat scan", 1'b1, d[2])
    c.em_fault = 1'b1;
    c.em_error = 8'($random(seed));
    put(2);
    `CHK("em code", {DK_ERROR, c.em_error}, ind.em_disp)
    c.em_fault = 1'b0;
    put(3 * H);
    `CHK("em held", {DK_ERROR, c.em_error}, ind.em_disp)
    rd(REG_STATE);
    `CHK("em state", 1'b1, d[3])
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    tick(4);
    `CHK("em cleared", 1'b1, ind.em_disp.kind != DK_ERROR)
    $display("test emitter done");
    final_report;
  end
endmodule
`default_nettype wire
